// ### include/drive_decode_if.sv
// drive number / motor enables to select and motor lines
// assumes the register bank drives the control side
`default_nettype none
interface drive_decode_if;
	logic [1:0] drive_num;
	logic [3:0] motor_en;
	logic swap_drives;
	logic external_decode;
	logic [3:0] drive_select_n;
	logic [3:0] motor_on_n;
	modport ctrl (output drive_num, output motor_en, output swap_drives,
		output external_decode, input drive_select_n, input motor_on_n);
	modport decode (input drive_num, input motor_en, input swap_drives,
		input external_decode, output drive_select_n, output motor_on_n);
endinterface
`default_nettype wire

// ### include/fdc_regs_pkg.sv
// register map, field positions, reset values and timing counts of the
// floppy drive control register bank; assumes a 40 MHz core clock
`default_nettype none
package fdc_regs_pkg;
	localparam logic [2:0] OFS_DRIVE_OUT = 3'h2;
	localparam logic [2:0] OFS_TAPE = 3'h3;
	localparam logic [2:0] OFS_STATUS_RATE = 3'h4;
	localparam logic [2:0] OFS_DATA = 3'h5;
	localparam logic [2:0] OFS_INPUT_CONFIG = 3'h7;
	localparam int REG_W = 8;
	// drive output control fields
	localparam int DOC_DRV_LO = 0;
	localparam int DOC_RESET_N = 2;
	localparam int DOC_DMA_GATE = 3;
	localparam int DOC_MOTOR_LO = 4;
	localparam logic [7:0] DOC_RESET_VAL = 8'h00;
	// rate / precompensation select fields
	localparam int RPS_RATE_LO = 0;
	localparam int RPS_PRECOMP_LO = 2;
	localparam int RPS_RESERVED = 5;
	localparam int RPS_LOW_POWER = 6;
	localparam int RPS_SOFT_RESET = 7;
	localparam logic [7:0] RPS_RESET_VAL = 8'h02;
	localparam logic [1:0] RATE_RESET_VAL = 2'h2;
	localparam logic [1:0] TAPE_RESET_VAL = 2'h0;
	// media polarity positions in the boot config byte, and the disk change bit
	localparam int BPC_ID1_POL = 3;
	localparam int BPC_ID0_POL = 2;
	localparam int DISK_CHANGE_BIT = 7;
	// soft reset minimum width
	localparam int CLK_MHZ = 40;
	localparam int SOFT_RST_MIN_NS = 100;
	localparam int SOFT_RST_CYC = (SOFT_RST_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int PIN_W = 19;
endpackage
`default_nettype wire

// ### src/drive_decode.sv
// select and motor line decode, internal four-drive or external 2-to-4
// assumes drive number and motor enables are registered by the register bank; swap and external decode come straight from its inputs
`default_nettype none
module drive_decode
	import fdc_regs_pkg::*;
(
	drive_decode_if.decode dd
);
	logic [1:0] num;
	always_comb begin
		num = dd.drive_num;
		// swapping exchanges drives 0 and 1 only
		if (dd.swap_drives && !dd.drive_num[1]) begin
			num = {1'b0, ~dd.drive_num[0]};
		end
		dd.drive_select_n = 4'hF;
		dd.motor_on_n = 4'hF;
		if (dd.external_decode) begin
			dd.drive_select_n[1:0] = num;
			dd.motor_on_n[0] = ~dd.motor_en[dd.drive_num];
		end else begin
			if (dd.motor_en[dd.drive_num]) begin
				dd.drive_select_n[num] = 1'b0;
			end
			dd.motor_on_n = ~dd.motor_en;
			if (dd.swap_drives) begin
				dd.motor_on_n[1:0] = {~dd.motor_en[0], ~dd.motor_en[1]};
			end
		end
	end
endmodule // drive_decode
`default_nettype wire

// ### src/fdc_ctrl_regs.sv
// floppy drive control register bank: host byte port, drive outputs,
// tape/media register, rate select and soft reset
// assumes the configuration block supplies enable, mode and config bytes
// Behaviour
// - all registers are eight bits wide
// - decode offsets 2,3,4,5,7; 0,1,6 unsupported
// - block silent until configuration enables it
// - status A/B blocked in configuration mode
// - drive output control zero on hardware reset
// - bits 1:0 pick at most one drive
// - bit 2 low holds core reset
// - soft reset stretched to 100ns minimum
// - bit 3 gates DMA and interrupt lines
// - bits 7:4 drive motor lines 0..3 in internal decode; external decode uses line 0 only
// - internal normal decode, select needs motor bit
// - internal swapped decode exchanges drives 0,1
// - external swapped decode exchanges codes 0,1
// - normal tape register: bits 1:0, rest floating
// - enhanced mode: media pins on bits 7:6
// - bits 5:4 show drive type pair
// - rate select write-only, hardware reset 02h
// - last rate write of either register wins
// - rate select bit 7 pulses core reset
`default_nettype none
module fdc_ctrl_regs
	import fdc_regs_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic cs_n,
	input wire logic ior_n,
	input wire logic iow_n,
	input wire logic [2:0] addr,
	input wire logic [7:0] host_data_in,
	output logic [7:0] host_data_out,
	output logic [7:0] host_data_oe_n,
	input wire logic block_enable,
	input wire logic config_mode,
	input wire logic enhanced_mode_two,
	input wire logic swap_drives,
	input wire logic external_decode,
	input wire logic [7:0] drive_type_config,
	input wire logic [7:0] boot_polarity_config,
	input wire logic [1:0] media_identity_in,
	input wire logic disk_change_n,
	input wire logic dma_acknowledge_n,
	input wire logic transfer_count_end,
	input wire logic [7:0] main_controller_status,
	input wire logic [7:0] command_data_rd,
	output logic [7:0] command_data_wr,
	output logic command_data_wr_pulse,
	output logic command_data_rd_pulse,
	input wire logic core_dma_request,
	input wire logic core_irq,
	output logic dma_request,
	output logic dma_request_oe_n,
	output logic irq,
	output logic irq_oe_n,
	output logic core_dma_acknowledge_n,
	output logic core_transfer_count_end,
	output logic core_soft_reset_n,
	output logic [1:0] rate_code,
	output logic [2:0] precomp_code,
	output logic low_power,
	output logic [1:0] tape_unit,
	output logic [3:0] drive_select_n,
	output logic [3:0] motor_on_n
);
	// ************************************************************
	// pin synchroniser, a change counts once stages two and three agree
	// ************************************************************
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] s1_ff, s2_ff, s3_ff, pin_ff;
	logic [PIN_W-1:0] nxt_pin;
	assign pin_raw = {cs_n, ior_n, iow_n, addr, host_data_in, media_identity_in,
		disk_change_n, dma_acknowledge_n, transfer_count_end};
	always_comb begin
		for (int i = 0; i < PIN_W; i++) begin
			nxt_pin[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : pin_ff[i];
		end
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s1_ff <= '1;
			s2_ff <= '1;
			s3_ff <= '1;
			pin_ff <= '1;
		end else begin
			s1_ff <= pin_raw;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			pin_ff <= nxt_pin;
		end
	end
	logic p_cs_n, p_ior_n, p_iow_n, p_dskchg_n, p_dack_n, p_tc;
	logic [2:0] p_addr;
	logic [7:0] p_data;
	logic [1:0] p_media;
	assign {p_cs_n, p_ior_n, p_iow_n, p_addr, p_data, p_media,
		p_dskchg_n, p_dack_n, p_tc} = pin_ff;

	// ************************************************************
	// strobe edges and address latch
	// ************************************************************
	logic ior_d_ff, iow_d_ff, nxt_ior_d, nxt_iow_d;
	logic sel_ff, nxt_sel;
	logic [2:0] addr_ff, nxt_addr;
	logic rd_lead, wr_lead, wr_trail;
	assign rd_lead = ior_d_ff & ~p_ior_n;
	assign wr_lead = iow_d_ff & ~p_iow_n;
	assign wr_trail = ~iow_d_ff & p_iow_n;
	always_comb begin
		nxt_ior_d = p_ior_n;
		nxt_iow_d = p_iow_n;
		nxt_sel = sel_ff;
		nxt_addr = addr_ff;
		if (rd_lead || wr_lead) begin
			nxt_sel = ~p_cs_n & block_enable;
			nxt_addr = p_addr;
		end
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ior_d_ff <= 1'b1;
			iow_d_ff <= 1'b1;
			sel_ff <= 1'b0;
			addr_ff <= 3'h0;
		end else begin
			ior_d_ff <= nxt_ior_d;
			iow_d_ff <= nxt_iow_d;
			sel_ff <= nxt_sel;
			addr_ff <= nxt_addr;
		end
	end
	logic wr_go;
	assign wr_go = wr_trail & sel_ff & block_enable;

	// ************************************************************
	// writable registers
	// ************************************************************
	logic [REG_W-1:0] doc_ff, nxt_doc;
	logic [REG_W-1:0] rps_ff, nxt_rps;
	logic [1:0] rate_ff, nxt_rate;
	logic [1:0] tape_ff, nxt_tape;
	logic rst_pulse;
	always_comb begin
		nxt_doc = doc_ff;
		nxt_rps = rps_ff;
		nxt_rate = rate_ff;
		nxt_tape = tape_ff;
		// soft reset bit of rate select clears itself after one cycle
		nxt_rps[RPS_SOFT_RESET] = 1'b0;
		// unsupported offsets fall through every branch
		if (wr_go && addr_ff == OFS_DRIVE_OUT) begin
			nxt_doc = p_data;
		end else if (wr_go && addr_ff == OFS_TAPE) begin
			nxt_tape = p_data[1:0];
		end else if (wr_go && addr_ff == OFS_STATUS_RATE) begin
			nxt_rps = p_data;
			nxt_rps[RPS_RESERVED] = 1'b0;
			nxt_rate = p_data[RPS_RATE_LO +: 2];
		end else if (wr_go && addr_ff == OFS_INPUT_CONFIG) begin
			nxt_rate = p_data[RPS_RATE_LO +: 2];
		end
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			doc_ff <= DOC_RESET_VAL;
			rps_ff <= RPS_RESET_VAL;
			rate_ff <= RATE_RESET_VAL;
			tape_ff <= TAPE_RESET_VAL;
		end else begin
			doc_ff <= nxt_doc;
			rps_ff <= nxt_rps;
			rate_ff <= nxt_rate;
			tape_ff <= nxt_tape;
		end
	end
	assign rst_pulse = rps_ff[RPS_SOFT_RESET];
	assign rate_code = rate_ff;
	assign precomp_code = rps_ff[RPS_PRECOMP_LO +: 3];
	assign low_power = rps_ff[RPS_LOW_POWER];
	assign tape_unit = tape_ff;

	// ************************************************************
	// core soft reset, held for a minimum width
	// ************************************************************
	localparam logic [3:0] SRST_LOAD = 4'(SOFT_RST_CYC);
	logic [3:0] srst_cnt_ff, nxt_srst_cnt;
	logic srst_req;
	assign srst_req = ~doc_ff[DOC_RESET_N] | rst_pulse;
	always_comb begin
		nxt_srst_cnt = srst_cnt_ff;
		if (srst_req) begin
			nxt_srst_cnt = SRST_LOAD;
		end else if (srst_cnt_ff != 4'h0) begin
			nxt_srst_cnt = srst_cnt_ff - 4'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			srst_cnt_ff <= SRST_LOAD;
		end else begin
			srst_cnt_ff <= nxt_srst_cnt;
		end
	end
	// only the controller core is reset; the registers here keep values
	assign core_soft_reset_n = ~srst_req & (srst_cnt_ff == 4'h0);

	// ************************************************************
	// read path and data port strobes
	// ************************************************************
	logic [7:0] rdata_ff, nxt_rdata;
	logic [7:0] oe_n_ff, nxt_oe_n;
	logic [7:0] tape_rd;
	logic [1:0] media_rd;
	logic rd_act;
	always_comb begin
		media_rd[1] = p_media[1] ^ boot_polarity_config[BPC_ID1_POL];
		media_rd[0] = p_media[0] ^ boot_polarity_config[BPC_ID0_POL];
		tape_rd = {media_rd,
			drive_type_config[{doc_ff[DOC_DRV_LO +: 2], 1'b1}],
			drive_type_config[{doc_ff[DOC_DRV_LO +: 2], 1'b0}],
			boot_polarity_config[1:0],
			tape_ff};
	end
	assign rd_act = ~p_ior_n & ~ior_d_ff & sel_ff & block_enable;
	always_comb begin
		nxt_rdata = rdata_ff;
		nxt_oe_n = 8'hFF;
		// offsets 0 and 1 (status A/B) never answer, so config mode
		// blocks them as well
		if (!rd_act || config_mode && addr_ff[2:1] == 2'h0) begin
			nxt_oe_n = 8'hFF;
		end else if (addr_ff == OFS_DRIVE_OUT) begin
			nxt_rdata = doc_ff;
			nxt_oe_n = 8'h00;
		end else if (addr_ff == OFS_TAPE) begin
			nxt_rdata = tape_rd;
			nxt_oe_n = enhanced_mode_two ? 8'h00 : 8'hFC;
		end else if (addr_ff == OFS_STATUS_RATE) begin
			nxt_rdata = main_controller_status;
			nxt_oe_n = 8'h00;
		end else if (addr_ff == OFS_DATA) begin
			nxt_rdata = command_data_rd;
			nxt_oe_n = 8'h00;
		end else if (addr_ff == OFS_INPUT_CONFIG) begin
			nxt_rdata = {~p_dskchg_n, 7'h00};
			nxt_oe_n = 8'h7F;
		end
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata_ff <= 8'h00;
			oe_n_ff <= 8'hFF;
		end else begin
			rdata_ff <= nxt_rdata;
			oe_n_ff <= nxt_oe_n;
		end
	end
	assign host_data_out = rdata_ff;
	assign host_data_oe_n = oe_n_ff;

	logic [7:0] cmd_wr_ff, nxt_cmd_wr;
	logic cmd_wr_p_ff, nxt_cmd_wr_p, cmd_rd_p_ff, nxt_cmd_rd_p;
	always_comb begin
		nxt_cmd_wr = cmd_wr_ff;
		nxt_cmd_wr_p = wr_go && addr_ff == OFS_DATA;
		nxt_cmd_rd_p = 1'b0;
		if (nxt_cmd_wr_p) begin
			nxt_cmd_wr = p_data;
		end
		if (rd_lead && ~p_cs_n && block_enable && p_addr == OFS_DATA) begin
			nxt_cmd_rd_p = 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cmd_wr_ff <= 8'h00;
			cmd_wr_p_ff <= 1'b0;
			cmd_rd_p_ff <= 1'b0;
		end else begin
			cmd_wr_ff <= nxt_cmd_wr;
			cmd_wr_p_ff <= nxt_cmd_wr_p;
			cmd_rd_p_ff <= nxt_cmd_rd_p;
		end
	end
	assign command_data_wr = cmd_wr_ff;
	assign command_data_wr_pulse = cmd_wr_p_ff;
	assign command_data_rd_pulse = cmd_rd_p_ff;

	// ************************************************************
	// DMA and interrupt gating
	// ************************************************************
	logic gate;
	assign gate = doc_ff[DOC_DMA_GATE];
	assign dma_request = core_dma_request;
	assign dma_request_oe_n = ~gate;
	assign irq = core_irq;
	assign irq_oe_n = ~gate;
	assign core_dma_acknowledge_n = p_dack_n | ~gate;
	assign core_transfer_count_end = p_tc & ~p_dack_n & gate;

	// ************************************************************
	// drive select and motor decode
	// ************************************************************
	drive_decode_if ddi ();
	assign ddi.drive_num = doc_ff[DOC_DRV_LO +: 2];
	assign ddi.motor_en = doc_ff[DOC_MOTOR_LO +: 4];
	assign ddi.swap_drives = swap_drives;
	assign ddi.external_decode = external_decode;
	drive_decode u_decode (
		.dd(ddi.decode)
	);
	assign drive_select_n = ddi.drive_select_n;
	assign motor_on_n = ddi.motor_on_n;
endmodule // fdc_ctrl_regs
`default_nettype wire

// ### verif/fdc_ctrl_regs_bench.sv
// self-checking bench for the floppy drive control register bank
// assumes io_host for bus cycles and the bound port checker
`default_nettype none
module fdc_ctrl_regs_bench import fdc_regs_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rstn = 1'b0, block_enable = 1'b1, config_mode, enhanced_mode_two;
	logic swap_drives, external_decode, disk_change_n, dma_acknowledge_n, transfer_count_end;
	logic core_dma_request, core_irq, cs_n, ior_n, iow_n, command_data_wr_pulse, seen_ff;
	logic command_data_rd_pulse, dma_request, dma_request_oe_n, irq, irq_oe_n;
	logic core_dma_acknowledge_n, core_transfer_count_end, core_soft_reset_n, low_power;
	logic [1:0] media_identity_in, rate_code, tape_unit;
	logic [2:0] addr, precomp_code;
	logic [3:0] drive_select_n, motor_on_n;
	logic [7:0] host_data_in, host_data_out, host_data_oe_n, drive_type_config;
	logic [7:0] boot_polarity_config, main_controller_status, command_data_rd, command_data_wr;
	logic [7:0] v, t, r, q, oe;
	logic [2:0] bad [3] = '{3'h0, 3'h1, 3'h6};
	int n_fail = 0, checks = 0, cyc = 0, n_wp = 0, n_rp = 0;
	fdc_ctrl_regs dut (.clk, .rstn, .cs_n, .ior_n, .iow_n, .addr, .host_data_in, .host_data_out,
		.host_data_oe_n, .block_enable, .config_mode, .enhanced_mode_two, .swap_drives,
		.external_decode, .drive_type_config, .boot_polarity_config, .media_identity_in,
		.disk_change_n, .dma_acknowledge_n, .transfer_count_end, .main_controller_status,
		.command_data_rd, .command_data_wr, .command_data_wr_pulse, .command_data_rd_pulse,
		.core_dma_request, .core_irq, .dma_request, .dma_request_oe_n, .irq, .irq_oe_n,
		.core_dma_acknowledge_n, .core_transfer_count_end, .core_soft_reset_n, .rate_code,
		.precomp_code, .low_power, .tape_unit, .drive_select_n, .motor_on_n);
	io_host host (.clk, .rdata(host_data_out), .roe(host_data_oe_n), .cs_n, .ior_n, .iow_n,
		.addr, .dq(host_data_in));
	// ****
	// model and helpers
	// ****
	always #12.5 clk = ~clk;
	always @(posedge clk) if (!core_soft_reset_n) seen_ff <= 1'b1;
	// data port strobes counted mid-cycle, away from the launching edge
	always @(negedge clk) begin
		n_wp += command_data_wr_pulse;
		n_rp += command_data_rd_pulse;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			test_done;
		end
	end
	// expected {selects, motors} for the chosen decode
	function automatic logic [7:0] dec(input logic [7:0] d, input logic sw, ex);
		logic [1:0] n;
		logic [3:0] m, s;
		n = (sw && !d[1]) ? {1'b0, !d[0]} : d[1:0];
		m = sw ? {d[7:6], d[4], d[5]} : d[7:4];
		s = 4'hF;
		s[n] = !m[n];
		if (ex)
			return {2'h3, n, 3'h7, !d[4 + d[1:0]]};
		return {s, ~m};
	endfunction
	task automatic chk(input logic [15:0] got, exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		host.acc(a, d, 1'b0, q, oe);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] eq, eoe);
		host.acc(a, 8'h00, 1'b1, q, oe);
		chk({oe, q & ~oe}, {eoe, eq & ~eoe});
	endtask
	task automatic rnd;
		{swap_drives, external_decode, enhanced_mode_two, config_mode, media_identity_in} = 6'($urandom);
		{disk_change_n, dma_acknowledge_n, transfer_count_end, core_dma_request, core_irq} = 5'($urandom);
		{drive_type_config, boot_polarity_config, main_controller_status, command_data_rd} = $urandom;
	endtask
	task automatic hw_reset;
		@(posedge clk) #2 rstn = 1'b0;
		repeat (8) @(posedge clk);
		#2 rstn = 1'b1;
		repeat (4) @(posedge clk);
		#2;
		chk({rate_code, precomp_code, tape_unit, core_soft_reset_n}, 8'h80);
		chk({drive_select_n, motor_on_n}, dec(8'h00, swap_drives, external_decode));
		rd(OFS_DRIVE_OUT, 8'h00, 8'h00);
	endtask
	task automatic test_done;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ****
	// scenarios
	// ****
	initial begin
		void'($urandom(43956));
		rnd;
		hw_reset;
		block_enable = 1'b0;
		wr(OFS_DRIVE_OUT, 8'hFF);
		rd(OFS_DRIVE_OUT, 8'h00, 8'hFF);
		block_enable = 1'b1;
		rd(OFS_DRIVE_OUT, 8'h00, 8'h00);
		wr(OFS_DRIVE_OUT, 8'h04);
		foreach (bad[i]) begin
			config_mode = bad[i] != 3'h6;
			wr(bad[i], 8'hFB);
			rd(bad[i], 8'h00, 8'hFF);
		end
		rd(OFS_DRIVE_OUT, 8'h04, 8'h00);
		for (int i = 0; i < 40; i++) begin
			rnd;
			v = 8'($urandom);
			wr(OFS_DRIVE_OUT, v);
			rd(OFS_DRIVE_OUT, v, 8'h00);
			chk({drive_select_n, motor_on_n}, dec(v, swap_drives, external_decode));
			chk({dma_request_oe_n, irq_oe_n, core_dma_acknowledge_n, core_transfer_count_end,
				dma_request, irq}, {v[3] ? {2'h0, dma_acknowledge_n,
				transfer_count_end & !dma_acknowledge_n} : 4'hE, core_dma_request, core_irq});
			chk(core_soft_reset_n, v[2]);
			t = 8'($urandom);
			wr(OFS_TAPE, t);
			rd(OFS_TAPE, {media_identity_in ^ boot_polarity_config[3:2],
				drive_type_config[2 * v[1:0] +: 2], boot_polarity_config[1:0], t[1:0]},
				enhanced_mode_two ? 8'h00 : 8'hFC);
			chk(tape_unit, t[1:0]);
			r = 8'($urandom) & 8'h5F;
			wr(OFS_STATUS_RATE, r);
			chk({low_power, precomp_code, rate_code}, {r[6], r[4:0]});
			wr(OFS_INPUT_CONFIG, t);
			chk({precomp_code, rate_code}, {r[4:2], t[1:0]});
			rd(OFS_INPUT_CONFIG, {!disk_change_n, 7'h00}, 8'h7F);
			rd(OFS_STATUS_RATE, main_controller_status, 8'h00);
			wr(OFS_DATA, r);
			chk(command_data_wr, r);
			rd(OFS_DATA, command_data_rd, 8'h00);
		end
		chk({8'(n_wp), 8'(n_rp)}, 16'h2828);
		wr(OFS_DRIVE_OUT, 8'h1C);
		seen_ff = 1'b0;
		wr(OFS_STATUS_RATE, 8'h81);
		chk({seen_ff, core_soft_reset_n, rate_code}, 4'hD);
		rd(OFS_DRIVE_OUT, 8'h1C, 8'h00);
		hw_reset;
		test_done;
	end
endmodule // fdc_ctrl_regs_bench
bind fdc_ctrl_regs fdc_ctrl_regs_sva sva (.clk, .rstn, .ior_n, .block_enable, .external_decode,
	.core_dma_request, .core_irq, .host_data_oe_n, .dma_request, .dma_request_oe_n, .irq,
	.irq_oe_n, .core_dma_acknowledge_n, .core_transfer_count_end, .core_soft_reset_n,
	.rate_code, .drive_select_n, .motor_on_n);
`default_nettype wire

// ### verif/fdc_ctrl_regs_sva.sv
// port checker for the floppy drive control register bank
// assumes it is bound to the top module by the bench
`default_nettype none
module fdc_ctrl_regs_sva (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ior_n,
	input wire logic block_enable,
	input wire logic external_decode,
	input wire logic core_dma_request,
	input wire logic core_irq,
	input wire logic [7:0] host_data_oe_n,
	input wire logic dma_request,
	input wire logic dma_request_oe_n,
	input wire logic irq,
	input wire logic irq_oe_n,
	input wire logic core_dma_acknowledge_n,
	input wire logic core_transfer_count_end,
	input wire logic core_soft_reset_n,
	input wire logic [1:0] rate_code,
	input wire logic [3:0] drive_select_n,
	input wire logic [3:0] motor_on_n
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****
	// properties
	// ****
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	a_one_select: assert property (!external_decode |-> $countones(~drive_select_n) <= 1)
		else $error("more than one select low");
	a_select_motor: assert property (!external_decode |-> (~drive_select_n & motor_on_n) == 4'h0)
		else $error("select low without its motor");
	a_ext_lines: assert property (external_decode |-> motor_on_n[3:1] == 3'h7 && drive_select_n[3:2] == 2'h3)
		else $error("external decode spare lines active");
	a_dma_off: assert property (dma_request_oe_n |-> irq_oe_n && core_dma_acknowledge_n && !core_transfer_count_end)
		else $error("dma lines live while gated");
	a_dma_pass: assert property (!dma_request_oe_n |-> !irq_oe_n && dma_request == core_dma_request && irq == core_irq)
		else $error("dma lines not passed through");
	a_rst_width: assert property ($fell(core_soft_reset_n) |=> !core_soft_reset_n [*3])
		else $error("soft reset too short");
	a_quiet_off: assert property (!block_enable [*2] |-> host_data_oe_n == 8'hFF)
		else $error("disabled block drives the bus");
	a_idle_float: assert property (ior_n [*8] |-> host_data_oe_n == 8'hFF)
		else $error("bus driven without a read");
	a_hw_reset: assert property ($rose(rstn) |-> rate_code == 2'h2 && motor_on_n == 4'hF && !core_soft_reset_n)
		else $error("wrong state after reset");
endmodule // fdc_ctrl_regs_sva
`default_nettype wire

// ### verif/io_host.sv
// host processor model on the 8-bit strobe bus
// assumes one access at a time, called from the bench
`default_nettype none
module io_host (
	input wire logic clk,
	input wire logic [7:0] rdata,
	input wire logic [7:0] roe,
	output logic cs_n,
	output logic ior_n,
	output logic iow_n,
	output logic [2:0] addr,
	output logic [7:0] dq
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****
	// bus cycle
	// ****
	initial {cs_n, ior_n, iow_n, addr, dq} = 14'h3FFF;
	// strobe low 8 clocks, high 12: beats the pin filter and the commit delay
	task automatic acc(input logic [2:0] a, input logic [7:0] d, input logic rd,
		output logic [7:0] q, output logic [7:0] oe);
		@(posedge clk) #2;
		addr = a;
		dq = d;
		cs_n = 1'b0;
		ior_n = !rd;
		iow_n = rd;
		repeat (8) @(posedge clk);
		q = rdata;
		oe = roe;
		#2 {ior_n, iow_n} = 2'h3;
		repeat (12) @(posedge clk);
		#2 cs_n = 1'b1;
		dq = ~d;
		addr = ~a;
	endtask
endmodule // io_host
`default_nettype wire
